// ===== logic/tcfg_regs.svh
// register indices, bank slots, divider codes and reset values of the transceiver config bank
// assumes the serial interface decodes an 8-bit register index
`ifndef TCFG_REGS_SVH
`define TCFG_REGS_SVH

// register indices (register numbers)
`define TCFG_IDX_LOS_THRESH   8'h07
`define TCFG_IDX_RX_SHAPING   8'h08
`define TCFG_IDX_RX_RECOVERY  8'h09
`define TCFG_IDX_TX_PATH      8'h0A
`define TCFG_IDX_TX_OUTPUT    8'h0B

// every register clears to zero
`define TCFG_RESET_VALUE      8'h00
`define TCFG_UNMAPPED_READ    8'h00
`define TCFG_NUM_REGS         5

// bank order used by the register array
`define TCFG_SLOT_LOS         0
`define TCFG_SLOT_SHAPING     1
`define TCFG_SLOT_RECOVERY    2
`define TCFG_SLOT_TX_PATH     3
`define TCFG_SLOT_TX_OUTPUT   4

// largest legal divider code (divide by 32)
`define TCFG_DIV_MAX_CODE     3'h5
`define TCFG_DIV_FULL_RATE    3'h0

`endif

// ===== logic/tcfg_pkg.sv
// types of the transceiver config bank
// assumes tcfg_regs.svh holds the numeric constants
package tcfg_pkg;

  typedef enum logic [1:0] {
    TCFG_FD_AUTO   = 2'b00,
    TCFG_FD_10G3   = 2'b01,
    TCFG_FD_11G1   = 2'b10,
    TCFG_FD_TEST   = 2'b11
  } tcfg_fd_mode_t;

  typedef struct packed {
    logic       reserved7;
    logic [1:0] rx_out_deemphasis;
    logic       rx_driver_short_protect;
    logic [3:0] rx_out_amplitude;
  } tcfg_rx_shaping_t;

  typedef struct packed {
    tcfg_fd_mode_t rx_freq_detect_mode;
    logic          rx_freq_detect_force_on;
    logic          rx_freq_detect_force_off;
    logic          rx_fast_lock_off;
    logic [2:0]    rx_rate_divider;
  } tcfg_rx_recovery_t;

  typedef struct packed {
    logic tx_power_down;
    logic tx_driver_off;
    logic tx_invert_polarity;
    logic tx_recovery_off;
    logic tx_recovery_bypass;
    logic tx_offset_cancel_off;
    logic tx_equalizer_off;
    logic tx_analog_amplitude_select;
  } tcfg_tx_path_t;

  // decoded receive controls
  typedef struct packed {
    logic [5:0]    rx_signal_loss_level;
    logic [1:0]    rx_out_deemphasis;
    logic          rx_driver_short_protect;
    logic [3:0]    rx_out_amplitude;
    tcfg_fd_mode_t rx_freq_detect_mode;
    logic          rx_freq_detect_on;
    logic          rx_freq_detect_auto;
    logic          rx_fast_lock_en;
    logic [2:0]    rx_div_log2;
    logic          rx_bypass_active;
  } tcfg_rx_ctl_t;

  // decoded transmit controls
  typedef struct packed {
    logic       tx_path_en;
    logic       tx_driver_en;
    logic       tx_invert_polarity;
    logic       tx_recovery_off;
    logic       tx_bypass_active;
    logic       tx_offset_cancel_en;
    logic       tx_equalizer_off;
    logic       tx_analog_amplitude_select;
    logic [7:0] tx_output_config;
  } tcfg_tx_ctl_t;

endpackage

// ===== logic/tcfg_reg8.sv
// one read/write configuration register with synchronous reset
// assumes write strobe and data are synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "tcfg_regs.svh"

module tcfg_reg8 #(
  parameter logic [7:0] RESET_VALUE = `TCFG_RESET_VALUE
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output var  logic [7:0] q
);

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RESET_VALUE;
    end else if (wr_en) begin
      q <= wr_data;
    end
  end

endmodule // tcfg_reg8

`default_nettype wire

// ===== logic/tcfg_top.sv
// transceiver receive/transmit configuration register bank
// assumes the two-wire serial interface delivers index, data and strobes on clk
`timescale 1ns/10ps
`default_nettype none
`include "tcfg_regs.svh"

module tcfg_top #(
  parameter int NUM_REGS = `TCFG_NUM_REGS
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  wr_en,
  input  wire logic [7:0]            reg_index,
  input  wire logic [7:0]            wr_data,
  input  wire logic                  rx_bypass_request,
  output var  logic [7:0]            rd_data,
  output var  logic                  rd_hit,
  output var  tcfg_pkg::tcfg_rx_ctl_t rx_ctl,
  output var  tcfg_pkg::tcfg_tx_ctl_t tx_ctl
);
  import tcfg_pkg::*;

  // ****************************************
  // register array
  // ****************************************
  localparam logic [7:0] SLOT_INDEX [NUM_REGS] = '{
    `TCFG_IDX_LOS_THRESH,
    `TCFG_IDX_RX_SHAPING,
    `TCFG_IDX_RX_RECOVERY,
    `TCFG_IDX_TX_PATH,
    `TCFG_IDX_TX_OUTPUT
  };

  logic [7:0]        bank [NUM_REGS];
  logic [NUM_REGS-1:0] slot_sel;

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      assign slot_sel[g] = (reg_index == SLOT_INDEX[g]);
      // all bits stored, reserved ones included, reset to zero
      tcfg_reg8 #(
        .RESET_VALUE (`TCFG_RESET_VALUE)
      ) u_reg (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_en && slot_sel[g]),
        .wr_data (wr_data),
        .q       (bank[g])
      );
    end
  endgenerate

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] next_rd_data;
  logic       next_rd_hit;

  always_comb begin
    next_rd_data = `TCFG_UNMAPPED_READ;
    next_rd_hit  = 1'b0;
    if (reg_index == `TCFG_IDX_LOS_THRESH) begin
      next_rd_data = bank[`TCFG_SLOT_LOS];
      next_rd_hit  = 1'b1;
    end else if (reg_index == `TCFG_IDX_RX_SHAPING) begin
      next_rd_data = bank[`TCFG_SLOT_SHAPING];
      next_rd_hit  = 1'b1;
    end else if (reg_index == `TCFG_IDX_RX_RECOVERY) begin
      next_rd_data = bank[`TCFG_SLOT_RECOVERY];
      next_rd_hit  = 1'b1;
    end else if (reg_index == `TCFG_IDX_TX_PATH) begin
      next_rd_data = bank[`TCFG_SLOT_TX_PATH];
      next_rd_hit  = 1'b1;
    end else if (reg_index == `TCFG_IDX_TX_OUTPUT) begin
      next_rd_data = bank[`TCFG_SLOT_TX_OUTPUT];
      next_rd_hit  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= `TCFG_RESET_VALUE;
      rd_hit  <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_hit  <= next_rd_hit;
    end
  end

  // ****************************************
  // field views
  // ****************************************
  tcfg_rx_shaping_t  shaping;
  tcfg_rx_recovery_t recovery;
  tcfg_tx_path_t     txp;
  logic              both_bypass;

  assign shaping     = tcfg_rx_shaping_t'(bank[`TCFG_SLOT_SHAPING]);
  assign recovery    = tcfg_rx_recovery_t'(bank[`TCFG_SLOT_RECOVERY]);
  assign txp         = tcfg_tx_path_t'(bank[`TCFG_SLOT_TX_PATH]);
  // bypass needs both ends set together
  assign both_bypass = txp.tx_recovery_bypass & rx_bypass_request;

  // ****************************************
  // receive control decode
  // ****************************************
  tcfg_rx_ctl_t next_rx_ctl;

  always_comb begin
    next_rx_ctl = '0;
    next_rx_ctl.rx_signal_loss_level    = bank[`TCFG_SLOT_LOS][5:0];
    next_rx_ctl.rx_out_deemphasis       = shaping.rx_out_deemphasis;
    next_rx_ctl.rx_driver_short_protect = shaping.rx_driver_short_protect;
    next_rx_ctl.rx_out_amplitude        = shaping.rx_out_amplitude;
    next_rx_ctl.rx_freq_detect_mode     = recovery.rx_freq_detect_mode;
    // force off dominates force on
    if (recovery.rx_freq_detect_force_off) begin
      next_rx_ctl.rx_freq_detect_on   = 1'b0;
      next_rx_ctl.rx_freq_detect_auto = 1'b0;
    end else if (recovery.rx_freq_detect_force_on) begin
      next_rx_ctl.rx_freq_detect_on   = 1'b1;
      next_rx_ctl.rx_freq_detect_auto = 1'b0;
    end else begin
      next_rx_ctl.rx_freq_detect_on   = 1'b0;
      next_rx_ctl.rx_freq_detect_auto = 1'b1;
    end
    next_rx_ctl.rx_fast_lock_en = ~recovery.rx_fast_lock_off;
    // undefined codes fall back to full rate
    if (recovery.rx_rate_divider <= `TCFG_DIV_MAX_CODE) begin
      next_rx_ctl.rx_div_log2 = recovery.rx_rate_divider;
    end else begin
      next_rx_ctl.rx_div_log2 = `TCFG_DIV_FULL_RATE;
    end
    next_rx_ctl.rx_bypass_active = both_bypass;
  end

  // ****************************************
  // transmit control decode
  // ****************************************
  tcfg_tx_ctl_t next_tx_ctl;

  always_comb begin
    next_tx_ctl = '0;
    next_tx_ctl.tx_path_en                 = ~txp.tx_power_down;
    next_tx_ctl.tx_driver_en               = ~txp.tx_driver_off;
    next_tx_ctl.tx_invert_polarity         = txp.tx_invert_polarity;
    next_tx_ctl.tx_recovery_off            = txp.tx_recovery_off;
    next_tx_ctl.tx_bypass_active           = both_bypass;
    next_tx_ctl.tx_offset_cancel_en        = ~txp.tx_offset_cancel_off;
    next_tx_ctl.tx_equalizer_off           = txp.tx_equalizer_off;
    next_tx_ctl.tx_analog_amplitude_select = txp.tx_analog_amplitude_select;
    next_tx_ctl.tx_output_config           = bank[`TCFG_SLOT_TX_OUTPUT];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_ctl <= '0;
      // zero recovery register decodes to fast lock and auto detect
      rx_ctl.rx_fast_lock_en     <= 1'b1;
      rx_ctl.rx_freq_detect_auto <= 1'b1;
    end else begin
      rx_ctl <= next_rx_ctl;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_ctl <= '0;
      // enables are active-high decodes of zero bits
      tx_ctl.tx_path_en          <= 1'b1;
      tx_ctl.tx_driver_en        <= 1'b1;
      tx_ctl.tx_offset_cancel_en <= 1'b1;
    end else begin
      tx_ctl <= next_tx_ctl;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_write_readback: assert property (@(posedge clk) disable iff (rst)
    wr_en && reg_index == `TCFG_IDX_TX_PATH ##1 reg_index == `TCFG_IDX_TX_PATH && !wr_en
    |=> rd_data == $past(wr_data, 2))
    else $error("tx path register did not read back written value");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    !(slot_sel != '0) |=> rd_data == `TCFG_UNMAPPED_READ && !rd_hit)
    else $error("unmapped index did not read as zero");
  a_mapped_hit: assert property (@(posedge clk) disable iff (rst)
    slot_sel != '0 |=> rd_hit)
    else $error("mapped index did not flag a hit");
  a_los_level: assert property (@(posedge clk) disable iff (rst)
    wr_en && reg_index == `TCFG_IDX_LOS_THRESH |=> ##1 rx_ctl.rx_signal_loss_level
      == $past(wr_data[5:0], 2))
    else $error("loss level output does not follow bits 5 to 0");
  a_los_follow: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> rx_ctl.rx_signal_loss_level == $past(bank[`TCFG_SLOT_LOS][5:0]))
    else $error("loss level output lost track of its register");
  a_deemph_map: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> rx_ctl.rx_out_deemphasis == $past(bank[`TCFG_SLOT_SHAPING][6:5]))
    else $error("de-emphasis output does not follow bits 6 to 5");
  a_short_protect: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> rx_ctl.rx_driver_short_protect == $past(bank[`TCFG_SLOT_SHAPING][4]))
    else $error("short-circuit protection does not follow bit 4");
  a_amp_map: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> rx_ctl.rx_out_amplitude == $past(bank[`TCFG_SLOT_SHAPING][3:0]))
    else $error("receive amplitude does not follow bits 3 to 0");
  a_fd_mode: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> rx_ctl.rx_freq_detect_mode == $past(bank[`TCFG_SLOT_RECOVERY][7:6]))
    else $error("detection mode does not follow bits 7 to 6");
  a_fd_force_off: assert property (@(posedge clk) disable iff (rst)
    recovery.rx_freq_detect_force_off |=> !rx_ctl.rx_freq_detect_on && !rx_ctl.rx_freq_detect_auto)
    else $error("frequency detector not held off");
  a_fd_force_on: assert property (@(posedge clk) disable iff (rst)
    recovery.rx_freq_detect_force_on && !recovery.rx_freq_detect_force_off
      |=> rx_ctl.rx_freq_detect_on)
    else $error("frequency detector not held on");
  a_fd_auto: assert property (@(posedge clk) disable iff (rst)
    !bank[`TCFG_SLOT_RECOVERY][5] && !bank[`TCFG_SLOT_RECOVERY][4]
      |=> rx_ctl.rx_freq_detect_auto && !rx_ctl.rx_freq_detect_on)
    else $error("frequency detector not in automatic mode");
  a_fast_lock: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> rx_ctl.rx_fast_lock_en == !$past(recovery.rx_fast_lock_off))
    else $error("fast lock does not follow its disable bit");
  a_divider_map: assert property (@(posedge clk) disable iff (rst)
    recovery.rx_rate_divider == 3'h5 |=> rx_ctl.rx_div_log2 == 3'h5)
    else $error("divide by 32 code not decoded");
  a_divider_fallback: assert property (@(posedge clk) disable iff (rst)
    recovery.rx_rate_divider > `TCFG_DIV_MAX_CODE
      |=> rx_ctl.rx_div_log2 == `TCFG_DIV_FULL_RATE)
    else $error("undefined divider code not decoded as full rate");
  a_power_down: assert property (@(posedge clk) disable iff (rst)
    $rose(txp.tx_power_down) |=> !tx_ctl.tx_path_en)
    else $error("transmit path not powered down");
  a_power_up: assert property (@(posedge clk) disable iff (rst)
    $fell(bank[`TCFG_SLOT_TX_PATH][7]) |=> tx_ctl.tx_path_en)
    else $error("transmit path not powered up");
  a_driver_off: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> tx_ctl.tx_driver_en == !$past(bank[`TCFG_SLOT_TX_PATH][6]))
    else $error("driver enable does not follow bit 6");
  a_polarity_map: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> tx_ctl.tx_invert_polarity == $past(bank[`TCFG_SLOT_TX_PATH][5]))
    else $error("polarity does not follow bit 5");
  a_tx_recovery_off: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> tx_ctl.tx_recovery_off == $past(bank[`TCFG_SLOT_TX_PATH][4]))
    else $error("transmit recovery disable does not follow bit 4");
  a_bypass_pair: assert property (@(posedge clk) disable iff (rst)
    !(txp.tx_recovery_bypass && rx_bypass_request)
      |=> !tx_ctl.tx_bypass_active && !rx_ctl.rx_bypass_active)
    else $error("bypass active without both bits set");
  a_tx_bypass_both: assert property (@(posedge clk) disable iff (rst)
    bank[`TCFG_SLOT_TX_PATH][3] && rx_bypass_request |=> tx_ctl.tx_bypass_active)
    else $error("transmit bypass not active with both bits set");
  a_bypass_both: assert property (@(posedge clk) disable iff (rst)
    txp.tx_recovery_bypass && rx_bypass_request |=> rx_ctl.rx_bypass_active)
    else $error("receive bypass not active with both bits set");
  a_offset_cancel: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> tx_ctl.tx_offset_cancel_en == !$past(bank[`TCFG_SLOT_TX_PATH][2]))
    else $error("offset cancellation does not follow bit 2");
  a_equalizer_off: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> tx_ctl.tx_equalizer_off == $past(bank[`TCFG_SLOT_TX_PATH][1]))
    else $error("equalizer disable does not follow bit 1");
  a_amp_select: assert property (@(posedge clk) disable iff (rst)
    wr_en && reg_index == `TCFG_IDX_TX_PATH |=> ##1
      tx_ctl.tx_analog_amplitude_select == $past(wr_data[0], 2))
    else $error("amplitude select does not follow bit 0");
  a_tx_output_raw: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> tx_ctl.tx_output_config == $past(bank[`TCFG_SLOT_TX_OUTPUT]))
    else $error("transmit output register not passed through");
  a_reset_read: assert property (@(posedge clk)
    rst |=> rd_data == `TCFG_RESET_VALUE && !rd_hit)
    else $error("read port not cleared by reset");
  a_reset_bank: assert property (@(posedge clk)
    rst |=> (bank[`TCFG_SLOT_LOS] | bank[`TCFG_SLOT_SHAPING] | bank[`TCFG_SLOT_RECOVERY]
      | bank[`TCFG_SLOT_TX_PATH] | bank[`TCFG_SLOT_TX_OUTPUT]) == `TCFG_RESET_VALUE)
    else $error("register bank not cleared by reset");
  a_reset_rx_decode: assert property (@(posedge clk)
    rst |=> rx_ctl.rx_fast_lock_en && rx_ctl.rx_freq_detect_auto)
    else $error("receive decode wrong in reset");
  a_reset_tx_decode: assert property (@(posedge clk)
    rst |=> tx_ctl.tx_path_en && tx_ctl.tx_driver_en && tx_ctl.tx_offset_cancel_en)
    else $error("transmit decode wrong in reset");

endmodule // tcfg_top

`default_nettype wire

// ===== tb/tb_tcfg_top.sv
// self-checking bench of the transceiver receive/transmit configuration bank
// assumes tcfg_pkg and tcfg_regs.svh from logic/ are compiled ahead of this file
`timescale 1ns/10ps
`default_nettype none
`include "tcfg_regs.svh"

module tb_tcfg_top;
  import tcfg_pkg::*;

  logic         clk;
  logic         rst;
  logic         wr_en;
  logic [7:0]   reg_index;
  logic [7:0]   wr_data;
  logic         rx_bypass_request;
  logic [7:0]   rd_data;
  logic         rd_hit;
  tcfg_rx_ctl_t rx_ctl;
  tcfg_tx_ctl_t tx_ctl;
  logic [7:0]   m [7:11];
  int           n_fail;
  int           checks_done;

  tcfg_top #(.NUM_REGS(`TCFG_NUM_REGS)) i_tcfg_top (
    .clk               (clk),
    .rst               (rst),
    .wr_en             (wr_en),
    .reg_index         (reg_index),
    .wr_data           (wr_data),
    .rx_bypass_request (rx_bypass_request),
    .rd_data           (rd_data),
    .rd_hit            (rd_hit),
    .rx_ctl            (rx_ctl),
    .tx_ctl            (tx_ctl)
  );

  initial begin
    clk = 1'b0;
  end

  always #4 clk = ~clk;

  // ****************************************
  // expected values from the shadow registers
  // ****************************************
  function automatic logic mapped(input logic [7:0] idx);
    return (idx >= 8'h07) && (idx <= 8'h0B);
  endfunction

  function automatic tcfg_rx_ctl_t exp_rx();
    tcfg_rx_ctl_t e;
    e.rx_signal_loss_level    = m[7][5:0];
    e.rx_out_deemphasis       = m[8][6:5];
    e.rx_driver_short_protect = m[8][4];
    e.rx_out_amplitude        = m[8][3:0];
    e.rx_freq_detect_mode     = tcfg_fd_mode_t'(m[9][7:6]);
    e.rx_freq_detect_on       = m[9][5] & ~m[9][4];
    e.rx_freq_detect_auto     = ~m[9][5] & ~m[9][4];
    e.rx_fast_lock_en         = ~m[9][3];
    e.rx_div_log2             = (m[9][2:0] <= 3'h5) ? m[9][2:0] : 3'h0;
    e.rx_bypass_active        = m[10][3] & rx_bypass_request;
    return e;
  endfunction

  function automatic tcfg_tx_ctl_t exp_tx();
    tcfg_tx_ctl_t e;
    e.tx_path_en                 = ~m[10][7];
    e.tx_driver_en               = ~m[10][6];
    e.tx_invert_polarity         = m[10][5];
    e.tx_recovery_off            = m[10][4];
    e.tx_bypass_active           = m[10][3] & rx_bypass_request;
    e.tx_offset_cancel_en        = ~m[10][2];
    e.tx_equalizer_off           = m[10][1];
    e.tx_analog_amplitude_select = m[10][0];
    e.tx_output_config           = m[11];
    return e;
  endfunction

  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // reserved bits go out as zero, the test detection code never
  function automatic logic [7:0] legal(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (idx == `TCFG_IDX_LOS_THRESH) begin
      v[7:6] = 2'b00;
    end else if (idx == `TCFG_IDX_RX_SHAPING) begin
      v[7] = 1'b0;
    end else if (idx == `TCFG_IDX_RX_RECOVERY && v[7:6] == 2'b11) begin
      v[6] = 1'b0;
    end
    return v;
  endfunction

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    v = legal(idx, d);
    @(negedge clk);
    wr_en     = 1'b1;
    reg_index = idx;
    wr_data   = v;
    @(negedge clk);
    wr_en = 1'b0;
    if (mapped(idx)) begin
      m[idx] = v;
    end
  endtask

  task automatic rd(input logic [7:0] idx);
    @(negedge clk);
    reg_index = idx;
    @(negedge clk);
    chk(32'(rd_data), mapped(idx) ? 32'(m[idx]) : 32'h0, "read data");
    chk(32'(rd_hit), 32'(mapped(idx)), "read hit");
  endtask

  task automatic check_ctl();
    chk(32'(rx_ctl), 32'(exp_rx()), "rx controls");
    chk(32'(tx_ctl), 32'(exp_tx()), "tx controls");
  endtask

  task automatic wrc(input logic [7:0] idx, input logic [7:0] d);
    wr(idx, d);
    rd(idx);
    check_ctl();
  endtask

  task automatic read_all();
    for (int i = 7; i <= 11; i++) begin
      rd(8'(i));
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rst               = 1'b1;
    wr_en             = 1'b0;
    reg_index         = 8'h00;
    wr_data           = 8'h00;
    rx_bypass_request = 1'b0;
    n_fail            = 0;
    checks_done       = 0;
    for (int i = 7; i <= 11; i++) begin
      m[i] = 8'h00;
    end
    repeat (12) @(negedge clk);
    check_ctl();
    chk(32'(rd_data), 32'h0, "read data in reset");
    chk(32'(rd_hit), 32'h0, "read hit in reset");
    rst = 1'b0;
    read_all();
    check_ctl();
    // walking one through every non-reserved bit, bypass request low then high
    for (int b = 0; b < 2; b++) begin
      rx_bypass_request = b[0];
      for (int i = 7; i <= 11; i++) begin
        for (int k = 0; k < 8; k++) begin
          wrc(8'(i), 8'h01 << k);
        end
      end
    end
    for (int k = 0; k < 3; k++) begin
      wrc(`TCFG_IDX_RX_RECOVERY, 8'(k << 6));
    end
    for (int k = 0; k < 8; k++) begin
      wrc(`TCFG_IDX_RX_RECOVERY, 8'(k));
    end
    wrc(`TCFG_IDX_RX_RECOVERY, 8'h30);
    wrc(`TCFG_IDX_LOS_THRESH, 8'h3F);
    wrc(`TCFG_IDX_RX_SHAPING, 8'h7F);
    wrc(`TCFG_IDX_TX_PATH, 8'h08);
    rx_bypass_request = 1'b0;
    wrc(`TCFG_IDX_TX_PATH, 8'h08);
    for (int i = 7; i <= 11; i++) begin
      wrc(8'(i), 8'hFF);
      wrc(8'(i), 8'hA5);
    end
    // back-to-back writes on consecutive edges
    @(negedge clk);
    wr_en     = 1'b1;
    reg_index = `TCFG_IDX_LOS_THRESH;
    wr_data   = 8'h2A;
    @(negedge clk);
    reg_index = `TCFG_IDX_TX_OUTPUT;
    wr_data   = 8'h5C;
    @(negedge clk);
    wr_en = 1'b0;
    m[7]  = 8'h2A;
    m[11] = 8'h5C;
    read_all();
    check_ctl();
    // unmapped places take no write and read as zero
    wr(8'h06, 8'hFF);
    rd(8'h06);
    wr(8'h0C, 8'hFF);
    rd(8'h0C);
    wr(8'hFF, 8'hFF);
    rd(8'h00);
    rd(8'hFF);
    read_all();
    // reset in mid-run clears the bank and read port, controls return to their zero-register decode
    rx_bypass_request = 1'b1;
    for (int i = 7; i <= 11; i++) begin
      wr(8'(i), 8'hFF);
    end
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    for (int i = 7; i <= 11; i++) begin
      m[i] = 8'h00;
    end
    check_ctl();
    chk(32'(rd_data), 32'h0, "read data in reset");
    chk(32'(rd_hit), 32'h0, "read hit in reset");
    rst = 1'b0;
    read_all();
    check_ctl();
    summarize();
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    summarize();
  end

endmodule // tb_tcfg_top

`default_nettype wire
